/* File: chgpc_pkg.sv */
package chgpc_pkg;
   // ========================================
   // Timing
   localparam int unsigned CLK_HZ          = 50_000_000;
   localparam int unsigned ALERT_PULSE_US  = 256;
   localparam int unsigned ALERT_PULSE_CYC = (ALERT_PULSE_US * (CLK_HZ / 1_000_000));
   localparam logic [13:0] ALERT_CNT_LAST  = 14'(ALERT_PULSE_CYC - 1);

   // ========================================
   // Register byte offsets
   localparam logic [11:0] OFS_CTRL   = 12'h000;
   localparam logic [11:0] OFS_RLIM   = 12'h004;
   localparam logic [11:0] OFS_STATUS = 12'h008;
   localparam logic [11:0] OFS_IRQ_ST = 12'h00c;
   localparam logic [11:0] OFS_IRQ_MK = 12'h010;

   // ========================================
   // Reset values
   localparam logic [1:0]  CFG_RESET      = 2'h1;
   localparam logic [2:0]  LIMIT_RESET    = 3'h0;
   localparam logic [15:0] RES_LIMIT_RST  = 16'h01f4;
   localparam logic [15:0] RES_LIMIT_MIN  = 16'h01f4;
   localparam logic [4:0]  IRQ_MASK_RESET = 5'h00;

   // ========================================
   // Charge/boost configuration field codes
   localparam logic [1:0] CFG_CHARGE = 2'h1;
   localparam logic [1:0] CFG_BOOST  = 2'h2;

   // Interrupt status bits
   localparam int unsigned IRQ_CHG_ON   = 0;
   localparam int unsigned IRQ_CHG_OFF  = 1;
   localparam int unsigned IRQ_BOOST    = 2;
   localparam int unsigned IRQ_TEMP     = 3;
   localparam int unsigned IRQ_LIMIT    = 4;
   localparam int unsigned IRQ_W        = 5;

   // ========================================
   // Carried types
   typedef struct packed
   {
      logic source_usb;
      logic limit_boost;
      logic charge_en_n;
      logic temp_bad_a;
      logic temp_bad_b;
   } chgpc_pins_t;

   // Enable pin reads inactive until the synchroniser has filled
   localparam chgpc_pins_t PINS_RESET = 5'h04;

   typedef struct packed
   {
      logic        charging;
      logic        boosting;
      logic        temp_fault;
      logic [15:0] input_current_ma;
   } chgpc_state_t;

   typedef enum logic [0:0]
   {
      ALERT_IDLE  = 1'b0,
      ALERT_PULSE = 1'b1
   } chgpc_alert_st_t;
endpackage

/* File: chgpc_limit_sel.sv */
`timescale 1ns/1ps
`default_nettype none
module chgpc_limit_sel
(
   input  wire logic        source_usb_in,
   input  wire logic        limit_boost_in,
   input  wire logic [2:0]  input_limit_code_field_in,
   input  wire logic [15:0] resistor_limit_ma_in,
   output logic      [15:0] limit_ma_out
);
   logic [15:0] code_ma;
   logic [15:0] res_ma;
   logic [15:0] reg_ma;

   // ========================================
   // Code table in mA
   always_comb
   begin
      case (input_limit_code_field_in)
         3'h0:    code_ma = 16'h0064;
         3'h1:    code_ma = 16'h0096;
         3'h2:    code_ma = 16'h01f4;
         3'h3:    code_ma = 16'h0384;
         3'h4:    code_ma = 16'h04b0;
         3'h5:    code_ma = 16'h05dc;
         3'h6:    code_ma = 16'h07d0;
         default: code_ma = 16'h0bb8;
      endcase
   end

   always_comb
   begin
      // Resistor limit never below the floor
      res_ma = (resistor_limit_ma_in < chgpc_pkg::RES_LIMIT_MIN) ?
               chgpc_pkg::RES_LIMIT_MIN : resistor_limit_ma_in;
      // USB host source caps the register choice
      if (source_usb_in)
      begin
         reg_ma = limit_boost_in ? 16'h01f4 : 16'h0064;
         if (code_ma < reg_ma)
         begin
            reg_ma = code_ma;
         end
      end
      else
      begin
         reg_ma = code_ma;
      end
      limit_ma_out = (res_ma < reg_ma) ? res_ma : reg_ma;
   end
endmodule // chgpc_limit_sel
`default_nettype wire

/* File: chgpc_alert_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module chgpc_alert_gen
(
   input  wire logic mclk_in,
   input  wire logic reset_n_in,
   input  wire logic event_in,
   output logic      alert_n_out
);
   chgpc_pkg::chgpc_alert_st_t state_reg;
   logic [13:0]                cnt_reg;
   logic                       pend_reg;

   // ========================================
   // One fixed-length pulse per event; events during a pulse queue one more
   always_ff @(posedge mclk_in)
   begin
      if (!reset_n_in)
      begin
         state_reg   <= chgpc_pkg::ALERT_IDLE;
         cnt_reg     <= 14'h0000;
         pend_reg    <= 1'b0;
         alert_n_out <= 1'b1;
      end
      else
      begin
         case (state_reg)
            chgpc_pkg::ALERT_IDLE:
            begin
               if (event_in || pend_reg)
               begin
                  state_reg   <= chgpc_pkg::ALERT_PULSE;
                  cnt_reg     <= 14'h0000;
                  pend_reg    <= 1'b0;
                  alert_n_out <= 1'b0;
               end
            end
            chgpc_pkg::ALERT_PULSE:
            begin
               if (event_in)
               begin
                  pend_reg <= 1'b1;
               end
               if (cnt_reg == chgpc_pkg::ALERT_CNT_LAST)
               begin
                  // Release between pulses so the host sees each edge
                  state_reg   <= chgpc_pkg::ALERT_IDLE;
                  alert_n_out <= 1'b1;
               end
               else
               begin
                  cnt_reg <= cnt_reg + 14'h0001;
               end
            end
            default:
            begin
               state_reg   <= chgpc_pkg::ALERT_IDLE;
               alert_n_out <= 1'b1;
            end
         endcase
      end
   end
endmodule // chgpc_alert_gen
`default_nettype wire

/* File: chgpc_top.sv */
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Alert output pulses low for 256 us on status change or fault.
// - USB host source in buck mode: capped at 500 mA if pin high, else 100 mA.
// - Boost only when config field is 10 and limit/boost pin high.
// - Charging only when config field is 01 and charge-enable pin low.
// - Effective input limit is the smaller of resistor and register limits.
// - Resistor-set limit is never taken below 500 mA.
// - Any thermistor out of window suspends charge; resume when both good.
module chgpc_top
(
   input  wire logic        mclk_in,
   input  wire logic        reset_n_in,
   input  wire logic        source_select_pin_in,
   input  wire logic        usb_limit_boost_pin_in,
   input  wire logic        charge_enable_n_pin_in,
   input  wire logic        thermistor_sense_a_in,
   input  wire logic        thermistor_sense_b_in,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             alert_n_out,
   output logic             alert_oe_out,
   output logic             charge_en_out,
   output logic             boost_en_out,
   output logic [15:0]      input_current_limit_out,
   output logic             irq_out
);
   // ========================================
   // Pin synchronisers
   chgpc_pkg::chgpc_pins_t pins_meta_reg;
   chgpc_pkg::chgpc_pins_t pins_sync_reg;

   always_ff @(posedge mclk_in)
   begin
      if (!reset_n_in)
      begin
         // Reset must never look like a charge request on the enable pin
         pins_meta_reg <= chgpc_pkg::PINS_RESET;
         pins_sync_reg <= chgpc_pkg::PINS_RESET;
      end
      else
      begin
         pins_meta_reg <= {source_select_pin_in, usb_limit_boost_pin_in,
                           charge_enable_n_pin_in, thermistor_sense_a_in,
                           thermistor_sense_b_in};
         pins_sync_reg <= pins_meta_reg;
      end
   end

   // ========================================
   // Registers
   logic [1:0]  charge_boost_config_field_reg;
   logic [2:0]  input_limit_code_field_reg;
   logic [15:0] resistor_limit_reg;
   logic [chgpc_pkg::IRQ_W-1:0] irq_status_reg;
   logic [chgpc_pkg::IRQ_W-1:0] irq_mask_reg;
   logic        wr_en;
   logic        rd_en;
   logic        addr_ok;

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   assign addr_ok = (paddr == chgpc_pkg::OFS_CTRL) || (paddr == chgpc_pkg::OFS_RLIM) ||
                    (paddr == chgpc_pkg::OFS_STATUS) || (paddr == chgpc_pkg::OFS_IRQ_ST) ||
                    (paddr == chgpc_pkg::OFS_IRQ_MK);

   always_ff @(posedge mclk_in)
   begin
      if (!reset_n_in)
      begin
         charge_boost_config_field_reg <= chgpc_pkg::CFG_RESET;
         input_limit_code_field_reg    <= chgpc_pkg::LIMIT_RESET;
      end
      else if (wr_en && (paddr == chgpc_pkg::OFS_CTRL))
      begin
         charge_boost_config_field_reg <= pwdata[5:4];
         input_limit_code_field_reg    <= pwdata[2:0];
      end
   end

   // Software stands in for the measured resistor; the floor is applied later
   always_ff @(posedge mclk_in)
   begin
      if (!reset_n_in)
      begin
         resistor_limit_reg <= chgpc_pkg::RES_LIMIT_RST;
      end
      else if (wr_en && (paddr == chgpc_pkg::OFS_RLIM))
      begin
         resistor_limit_reg <= pwdata[15:0];
      end
   end

   always_ff @(posedge mclk_in)
   begin
      if (!reset_n_in)
      begin
         irq_mask_reg <= chgpc_pkg::IRQ_MASK_RESET;
      end
      else if (wr_en && (paddr == chgpc_pkg::OFS_IRQ_MK))
      begin
         irq_mask_reg <= pwdata[chgpc_pkg::IRQ_W-1:0];
      end
   end

   // ========================================
   // Mode decisions
   logic temp_fault;
   logic charge_next;
   logic boost_next;
   logic [15:0] limit_ma;

   // Either sensor out of window suspends; both must clear to resume
   assign temp_fault  = pins_sync_reg.temp_bad_a || pins_sync_reg.temp_bad_b;
   // Pin is trusted as driven; a floating input would toggle charging
   assign charge_next = (charge_boost_config_field_reg == chgpc_pkg::CFG_CHARGE) &&
                        !pins_sync_reg.charge_en_n && !temp_fault;
   assign boost_next  = (charge_boost_config_field_reg == chgpc_pkg::CFG_BOOST) &&
                        pins_sync_reg.limit_boost;

   chgpc_limit_sel u_limit_sel
   (
      .source_usb_in             (pins_sync_reg.source_usb),
      .limit_boost_in            (pins_sync_reg.limit_boost),
      .input_limit_code_field_in (input_limit_code_field_reg),
      .resistor_limit_ma_in      (resistor_limit_reg),
      .limit_ma_out              (limit_ma)
   );

   // Last cycle's decisions, compared against the new ones to spot events
   chgpc_pkg::chgpc_state_t state_reg;

   always_ff @(posedge mclk_in)
   begin
      if (!reset_n_in)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg.charging         <= charge_next;
         state_reg.boosting         <= boost_next;
         state_reg.temp_fault       <= temp_fault;
         state_reg.input_current_ma <= limit_ma;
      end
   end

   always_ff @(posedge mclk_in)
   begin
      if (!reset_n_in)
      begin
         charge_en_out <= 1'b0;
      end
      else
      begin
         charge_en_out <= charge_next;
      end
   end

   always_ff @(posedge mclk_in)
   begin
      if (!reset_n_in)
      begin
         boost_en_out <= 1'b0;
      end
      else
      begin
         boost_en_out <= boost_next;
      end
   end

   always_ff @(posedge mclk_in)
   begin
      if (!reset_n_in)
      begin
         input_current_limit_out <= chgpc_pkg::RES_LIMIT_MIN;
      end
      else
      begin
         input_current_limit_out <= limit_ma;
      end
   end

   // ========================================
   // Events
   logic [chgpc_pkg::IRQ_W-1:0] ev;
   logic                        any_event;

   // Charge edges, boost either way, new faults, any limit change
   assign ev[chgpc_pkg::IRQ_CHG_ON]  = charge_next && !state_reg.charging;
   assign ev[chgpc_pkg::IRQ_CHG_OFF] = !charge_next && state_reg.charging;
   assign ev[chgpc_pkg::IRQ_BOOST]   = boost_next != state_reg.boosting;
   assign ev[chgpc_pkg::IRQ_TEMP]    = temp_fault && !state_reg.temp_fault;
   assign ev[chgpc_pkg::IRQ_LIMIT]   = limit_ma != state_reg.input_current_ma;
   assign any_event = |ev;

   // Set beats write-one-to-clear in the same cycle
   always_ff @(posedge mclk_in)
   begin
      if (!reset_n_in)
      begin
         irq_status_reg <= '0;
      end
      else
      begin
         for (int i = 0; i < chgpc_pkg::IRQ_W; i++)
         begin
            if (ev[i])
            begin
               irq_status_reg[i] <= 1'b1;
            end
            else if (wr_en && (paddr == chgpc_pkg::OFS_IRQ_ST) && pwdata[i])
            begin
               irq_status_reg[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge mclk_in)
   begin
      if (!reset_n_in)
      begin
         irq_out <= 1'b0;
      end
      else
      begin
         irq_out <= |(irq_status_reg & irq_mask_reg);
      end
   end

   // ========================================
   // Open-drain alert
   logic alert_n;

   chgpc_alert_gen u_alert_gen
   (
      .mclk_in     (mclk_in),
      .reset_n_in  (reset_n_in),
      .event_in    (any_event),
      .alert_n_out (alert_n)
   );

   always_ff @(posedge mclk_in)
   begin
      if (!reset_n_in)
      begin
         alert_n_out <= 1'b1;
      end
      else
      begin
         alert_n_out <= alert_n;
      end
   end

   always_ff @(posedge mclk_in)
   begin
      if (!reset_n_in)
      begin
         alert_oe_out <= 1'b0;
      end
      else
      begin
         alert_oe_out <= !alert_n;
      end
   end

   // ========================================
   // APB slave: no wait states, reads registered
   logic        setup_rd;
   logic [31:0] prdata_next;

   // Decode in the setup cycle so read data stands with pready
   assign setup_rd = psel && !penable && !pwrite;

   always_comb
   begin
      prdata_next = 32'h0000_0000;
      if (setup_rd)
      begin
         case (paddr)
            chgpc_pkg::OFS_CTRL:
               prdata_next = {26'h0, charge_boost_config_field_reg, 1'b0,
                              input_limit_code_field_reg};
            chgpc_pkg::OFS_RLIM:   prdata_next = {16'h0, resistor_limit_reg};
            chgpc_pkg::OFS_STATUS: prdata_next = {13'h0, state_reg};
            chgpc_pkg::OFS_IRQ_ST: prdata_next = {27'h0, irq_status_reg};
            chgpc_pkg::OFS_IRQ_MK: prdata_next = {27'h0, irq_mask_reg};
            default:               prdata_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge mclk_in)
   begin
      if (!reset_n_in)
      begin
         pready <= 1'b0;
      end
      else
      begin
         pready <= psel && !penable;
      end
   end

   always_ff @(posedge mclk_in)
   begin
      if (!reset_n_in)
      begin
         pslverr <= 1'b0;
      end
      else
      begin
         pslverr <= psel && !penable && !addr_ok;
      end
   end

   always_ff @(posedge mclk_in)
   begin
      if (!reset_n_in)
      begin
         prdata <= 32'h0000_0000;
      end
      else
      begin
         prdata <= prdata_next;
      end
   end

   logic unused_rd;
   assign unused_rd = rd_en;
endmodule // chgpc_top
`default_nettype wire

/* File: chgpc_top_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module chgpc_top_chk
(
   input wire logic        mclk_in,
   input wire logic        reset_n_in,
   input wire logic        source_select_pin_in,
   input wire logic        usb_limit_boost_pin_in,
   input wire logic        charge_enable_n_pin_in,
   input wire logic        thermistor_sense_a_in,
   input wire logic        thermistor_sense_b_in,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        alert_n_out,
   input wire logic        alert_oe_out,
   input wire logic        charge_en_out,
   input wire logic        boost_en_out,
   input wire logic [15:0] input_current_limit_out
);
   // ==========
   // Helpers
   logic [1:0]  cfg_q;
   logic [15:0] low_q;
   // Mirror of the config field, seen only through bus writes
   always_ff @(posedge mclk_in)
   begin
      if (!reset_n_in)
         cfg_q <= chgpc_pkg::CFG_RESET;
      else if (psel && penable && pwrite && paddr == chgpc_pkg::OFS_CTRL)
         cfg_q <= pwdata[5:4];
   end
   always_ff @(posedge mclk_in)
   begin
      if (!reset_n_in || alert_n_out)
         low_q <= 16'h0000;
      else
         low_q <= low_q + 16'h0001;
   end
   // ==========
   // Properties
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!reset_n_in);
   a_alert_width: assert property (
      $rose(alert_n_out) |-> low_q == chgpc_pkg::ALERT_PULSE_CYC) else $error("alert width");
   a_alert_cap: assert property (
      low_q <= chgpc_pkg::ALERT_PULSE_CYC) else $error("alert held low");
   a_alert_oe: assert property (
      alert_oe_out == !alert_n_out) else $error("alert enable");
   a_boost_pin: assert property (
      boost_en_out |-> $past(usb_limit_boost_pin_in, 3)) else $error("boost pin");
   // Window of three covers the write-to-output lag
   a_boost_cfg: assert property (
      boost_en_out |-> cfg_q == 2'h2 || $past(cfg_q) == 2'h2 || $past(cfg_q, 2) == 2'h2)
      else $error("boost cfg");
   a_charge_pin: assert property (
      charge_en_out |-> !$past(charge_enable_n_pin_in, 3)) else $error("charge pin");
   a_charge_cfg: assert property (
      charge_en_out |-> cfg_q == 2'h1 || $past(cfg_q) == 2'h1 || $past(cfg_q, 2) == 2'h1)
      else $error("charge cfg");
   a_charge_temp: assert property (
      charge_en_out |-> !($past(thermistor_sense_a_in, 3) || $past(thermistor_sense_b_in, 3)))
      else $error("charge temp");
   a_usb_low: assert property (
      $past(source_select_pin_in, 3) && !$past(usb_limit_boost_pin_in, 3)
      |-> input_current_limit_out <= 16'h0064) else $error("usb low limit");
   a_usb_high: assert property (
      $past(source_select_pin_in, 3) && !boost_en_out
      |-> input_current_limit_out <= 16'h01f4) else $error("usb high limit");
   c_alert: cover property ($rose(alert_n_out));
   c_boost: cover property (boost_en_out);
   c_charge: cover property (charge_en_out);
endmodule // chgpc_top_chk
bind chgpc_top chgpc_top_chk i_chk
(
   .mclk_in(mclk_in), .reset_n_in(reset_n_in), .source_select_pin_in(source_select_pin_in),
   .usb_limit_boost_pin_in(usb_limit_boost_pin_in), .psel(psel), .penable(penable),
   .charge_enable_n_pin_in(charge_enable_n_pin_in), .pwrite(pwrite), .paddr(paddr),
   .thermistor_sense_a_in(thermistor_sense_a_in), .pwdata(pwdata), .alert_n_out(alert_n_out),
   .thermistor_sense_b_in(thermistor_sense_b_in), .alert_oe_out(alert_oe_out),
   .charge_en_out(charge_en_out), .boost_en_out(boost_en_out),
   .input_current_limit_out(input_current_limit_out)
);
`default_nettype wire

/* File: chgpc_host.sv */
`timescale 1ns/1ps
`default_nettype none
module chgpc_host
(
   input  wire logic                   mclk_in,
   input  wire chgpc_pkg::chgpc_pins_t want_in,
   input  wire logic                   alert_oe_in,
   input  wire logic                   clear_in,
   output var chgpc_pkg::chgpc_pins_t  pins_out,
   output logic                        alert_wire_out,
   output logic [7:0]                  pulses_out,
   output logic [15:0]                 width_out
);
   logic        wire_q;
   logic [15:0] run_q;
   always_comb
   begin
      pins_out             = want_in;
      // Never float the enable: anything but low reads as high
      pins_out.charge_en_n = (want_in.charge_en_n !== 1'b0);
   end
   // Pull-up on the open-drain line
   assign alert_wire_out = alert_oe_in ? 1'b0 : 1'b1;
   always_ff @(posedge mclk_in)
   begin
      wire_q <= alert_wire_out;
      run_q <= alert_wire_out ? 16'h0000 : run_q + 16'h0001;
      if (clear_in)
         pulses_out <= 8'h00;
      else if (wire_q && !alert_wire_out)
         pulses_out <= pulses_out + 8'h01;
      if (!wire_q && alert_wire_out)
         width_out <= run_q;
   end
endmodule // chgpc_host
`default_nettype wire

/* File: chgpc_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
module chgpc_top_test;
   logic        mclk_in;
   logic        reset_n_in;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        alert_n_out;
   logic        alert_oe_out;
   logic        charge_en_out;
   logic        boost_en_out;
   logic [15:0] lim;
   logic        irq_out;
   logic        alert_w;
   logic        clr;
   logic [7:0]  pulses;
   logic [15:0] width;
   logic [31:0] rd;
   logic        err;
   logic [15:0] rl;
   int          mismatches;
   int          n_tests;
   chgpc_pkg::chgpc_pins_t want;
   chgpc_pkg::chgpc_pins_t pins;
   logic [15:0] codes [8] = '{16'h0064, 16'h0096, 16'h01f4, 16'h0384,
                              16'h04b0, 16'h05dc, 16'h07d0, 16'h0bb8};
   chgpc_top i_dut
   (
      .mclk_in(mclk_in), .reset_n_in(reset_n_in), .source_select_pin_in(pins.source_usb),
      .usb_limit_boost_pin_in(pins.limit_boost), .charge_enable_n_pin_in(pins.charge_en_n),
      .thermistor_sense_a_in(pins.temp_bad_a), .thermistor_sense_b_in(pins.temp_bad_b),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .alert_n_out(alert_n_out),
      .alert_oe_out(alert_oe_out), .charge_en_out(charge_en_out), .boost_en_out(boost_en_out),
      .input_current_limit_out(lim), .irq_out(irq_out)
   );
   chgpc_host i_host
   (
      .mclk_in(mclk_in), .want_in(want), .alert_oe_in(alert_oe_out), .clear_in(clr),
      .pins_out(pins), .alert_wire_out(alert_w), .pulses_out(pulses), .width_out(width)
   );
   always #10 mclk_in = ~mclk_in;
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_in);
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk_in);
      penable <= 1'b1;
      do
      begin
         @(posedge mclk_in);
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Pin changes need the sync stages plus the output register
   task automatic pins_set(input logic [4:0] v);
      want <= v;
      tick(6);
   endtask
   function automatic logic [15:0] exp_lim(input logic [2:0] c, input logic [15:0] r,
                                           input logic u, input logic l);
      logic [15:0] m;
      logic [15:0] f;
      m = codes[c];
      f = (r < chgpc_pkg::RES_LIMIT_MIN) ? chgpc_pkg::RES_LIMIT_MIN : r;
      if (f < m)
         m = f;
      if (u && !l && m > 16'h0064)
         m = 16'h0064;
      if (u && l && m > 16'h01f4)
         m = 16'h01f4;
      return m;
   endfunction
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      tick(90000);
      mismatches++;
      test_done();
   end
   initial
   begin
      mclk_in = 1'b0;
      reset_n_in = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      want = 5'b00100;
      clr = 1'b0;
      mismatches = 0;
      n_tests = 0;
      tick(8);
      check("alert idle", alert_w, 1'b1);
      reset_n_in <= 1'b1;
      apb(1'b0, chgpc_pkg::OFS_CTRL, 32'h0);
      check("ctrl reset", rd, 32'h00000010);
      apb(1'b0, chgpc_pkg::OFS_RLIM, 32'h0);
      check("rlim reset", rd, 32'h000001f4);
      apb(1'b0, chgpc_pkg::OFS_IRQ_MK, 32'h0);
      check("mask reset", rd, 32'h0);
      apb(1'b0, 12'h014, 32'h0);
      check("unmapped err", err, 1'b1);
      check("unmapped data", rd, 32'h0);
      $display("test reset done");
      for (int i = 0; i < 16; i++)
      begin
         apb(1'b1, chgpc_pkg::OFS_CTRL, {26'h0, i[3:2], 4'h0});
         pins_set({1'b0, i[1], i[0], 2'b00});
         check("boost", boost_en_out, i[3:2] == 2'h2 && i[1]);
         check("charge", charge_en_out, i[3:2] == 2'h1 && !i[0]);
      end
      $display("test modes done");
      apb(1'b1, chgpc_pkg::OFS_CTRL, 32'h00000010);
      // Gray order: resume only after the second sensor clears
      for (int i = 0; i < 5; i++)
      begin
         pins_set({3'b000, i[1:0] ^ {1'b0, i[1]}});
         check("temp", charge_en_out, i[1:0] == 2'h0);
      end
      $display("test temp done");
      for (int i = 0; i < 64; i++)
      begin
         rl = i[5] ? 16'h09c4 : 16'h012c;
         apb(1'b1, chgpc_pkg::OFS_RLIM, {16'h0, rl});
         apb(1'b1, chgpc_pkg::OFS_CTRL, {26'h0, 2'h1, 1'b0, i[2:0]});
         pins_set({i[4], i[3], 3'b100});
         check("limit", lim, exp_lim(i[2:0], rl, i[4], i[3]));
      end
      apb(1'b0, chgpc_pkg::OFS_STATUS, 32'h0);
      check("status limit", rd[15:0], 16'h01f4);
      $display("test limit done");
      pins_set(5'b00100);
      // Let any queued pulses drain: at most two
      tick(26000);
      clr <= 1'b1;
      apb(1'b1, chgpc_pkg::OFS_IRQ_ST, 32'h0000001f);
      clr <= 1'b0;
      apb(1'b0, chgpc_pkg::OFS_IRQ_ST, 32'h0);
      check("irq cleared", rd, 32'h0);
      apb(1'b1, chgpc_pkg::OFS_IRQ_MK, 32'h00000001);
      pins_set(5'b00000);
      check("irq raised", irq_out, 1'b1);
      apb(1'b0, chgpc_pkg::OFS_IRQ_ST, 32'h0);
      check("irq charge on", rd[0], 1'b1);
      apb(1'b1, chgpc_pkg::OFS_IRQ_ST, 32'h00000001);
      tick(2);
      check("irq w1c", irq_out, 1'b0);
      tick(13000);
      check("one pulse", pulses, 8'h01);
      check("pulse width", width, 16'(chgpc_pkg::ALERT_PULSE_CYC));
      clr <= 1'b1;
      tick(1);
      clr <= 1'b0;
      pins_set(5'b00100);
      pins_set(5'b00000);
      check("irq again", irq_out, 1'b1);
      apb(1'b1, chgpc_pkg::OFS_IRQ_MK, 32'h0);
      tick(2);
      check("irq masked", irq_out, 1'b0);
      tick(27000);
      check("queued pulse", pulses, 8'h02);
      check("second width", width, 16'(chgpc_pkg::ALERT_PULSE_CYC));
      $display("test alert done");
      test_done();
   end
endmodule // chgpc_top_test
`default_nettype wire
